/* design/gpio_map.vh */
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// register indices; byte address is four times the index
`define IDX_PA_DATA      6'h00
`define IDX_PB_DATA      6'h01
`define IDX_PA_DIR       6'h04
`define IDX_PB_DIR       6'h05
`define IDX_PD_DATA      6'h30
`define IDX_PD_DIR       6'h31
`define IDX_PD_PAD       6'h32
`define IDX_PD_SEL       6'h33

// address split of the bus word address
`define ADDR_IDX_HI      7
`define ADDR_IDX_LO      2
`define ADDR_ALIGN       2'b00

// port widths
`define WIDE_W           8
`define PD_W             6

// reset values of control registers
`define DIR_RESET        8'h00
`define PD_CFG_RESET     6'h00
`define PIN_RESET        8'h00
`define PD_PIN_RESET     6'h00

// unimplemented upper bits of the narrow port read back as this
`define PD_UNUSED_BITS   2'b00
`define RD_PAD_WIDE      24'h000000

// narrow port line decode of {direction, pad control}
`define PAD_IN_PULLUP    2'b00
`define PAD_IN_FLOAT     2'b01
`define PAD_PUSH_PULL    2'b10
`define PAD_OPEN_DRAIN   2'b11

// lines that the shared subsystem drives when selected (1, 3, 4, 5)
`define PD_ALT_DRIVES    6'h3A
// two-wire lines (4, 5) are open drain whenever selected
`define PD_ALT_OD        6'h30

`endif

/* design/pin_sync.v */
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] level
);
    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    wire [WIDTH-1:0] agree;

    // a bit only moves once the last two stages agree
    assign agree = ~(s2_reg ^ s3_reg);

    // three stages; first stage feeds only the second
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= {WIDTH{1'b0}};
            s2_reg <= {WIDTH{1'b0}};
            s3_reg <= {WIDTH{1'b0}};
            level  <= {WIDTH{1'b0}};
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level  <= (agree & s3_reg) | (~agree & level);
        end
    end
endmodule
`default_nettype wire

/* design/wide_port.v */
`timescale 1ns/10ps
`default_nettype none
`include "gpio_map.vh"
module wide_port (
    input  wire                 clk,
    input  wire                 rst,
    input  wire [`WIDE_W-1:0]   wr_data,
    input  wire                 wr_latch,
    input  wire                 wr_dir,
    input  wire [`WIDE_W-1:0]   pin_in,
    output wire [`WIDE_W-1:0]   rd_data,
    output wire [`WIDE_W-1:0]   rd_dir,
    output reg  [`WIDE_W-1:0]   pin_out,
    output reg  [`WIDE_W-1:0]   pin_oe
);
    reg  [`WIDE_W-1:0] latch_reg;
    reg  [`WIDE_W-1:0] dir_reg;
    wire [`WIDE_W-1:0] pin_level;

    // data latch has no reset: its contents survive a reset
    always @(posedge clk) begin
        if (wr_latch) begin
            latch_reg <= wr_data;
        end
    end

    // direction bits, cleared by reset so every line is an input
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_reg <= `DIR_RESET;
        end else if (wr_dir) begin
            dir_reg <= wr_data;
        end
    end

    pin_sync #(
        .WIDTH (`WIDE_W)
    ) u_sync (
        .clk    (clk),
        .rst    (rst),
        .pin_in (pin_in),
        .level  (pin_level)
    );

    // output lines read the latch, input lines the sensed level
    assign rd_data = (dir_reg & latch_reg) | (~dir_reg & pin_level);
    assign rd_dir  = dir_reg;

    // pad drivers; value masked by direction so an unset latch never shows as unknown on an input line
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out <= `PIN_RESET;
            pin_oe  <= `PIN_RESET;
        end else begin
            pin_out <= latch_reg & dir_reg;
            pin_oe  <= dir_reg;
        end
    end
endmodule
`default_nettype wire

/* design/gpio_top.v */
// How it works
// - two eight-line ports and one six-line port, each line set in or out.
// - a line drives when its direction bit is one, else it is an input.
// - direction registers read back the value software last wrote.
// - reset clears every direction register, so all lines are inputs.
// - reset leaves the data latches as they were.
// - writing data to an input line only loads the latch, it stays undriven.
// - writing data to an output line loads the latch and drives the line.
// - reading an input line returns the level sensed on the pin.
// - reading an output line returns the latch, not the pin.
// - narrow decode: 00 pull-up in, 01 plain in, 10 push-pull, 11 drain.
// - a set select bit hands the narrow line to timer or two-wire logic.
// - select overrides direction for drive and for the data read-back; the 00 decode still picks pull-up, lines 4, 5 always drain.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_map.vh"
module gpio_top (
    input  wire                 CLK,
    input  wire                 RST,
    input  wire                 PSEL,
    input  wire                 PENABLE,
    input  wire                 PWRITE,
    input  wire [7:0]           PADDR,
    input  wire [31:0]          PWDATA,
    output reg  [31:0]          PRDATA,
    output reg                  PREADY,
    output reg                  PSLVERR,
    input  wire [`WIDE_W-1:0]   PA_IN,
    output wire [`WIDE_W-1:0]   PA_OUT,
    output wire [`WIDE_W-1:0]   PA_OE,
    input  wire [`WIDE_W-1:0]   PB_IN,
    output wire [`WIDE_W-1:0]   PB_OUT,
    output wire [`WIDE_W-1:0]   PB_OE,
    input  wire [`PD_W-1:0]     PD_IN,
    output reg  [`PD_W-1:0]     PD_OUT,
    output reg  [`PD_W-1:0]     PD_OE,
    output reg  [`PD_W-1:0]     PD_PULLUP,
    input  wire [`PD_W-1:0]     ALT_OUT,
    output reg  [`PD_W-1:0]     PD_ALT_IN
);
    // bus slave states
    localparam ST_IDLE = 1'b0;
    localparam ST_ACK  = 1'b1;

    reg                 state_reg;
    reg                 state_next;
    wire [5:0]          idx;
    wire                aligned;
    reg                 hit;
    reg  [`WIDE_W-1:0]  rd_byte;
    reg  [31:0]         prdata_next;
    reg                 pready_next;
    reg                 pslverr_next;
    wire                access;
    wire                commit;

    // write strobes
    wire                wr_pa_data;
    wire                wr_pb_data;
    wire                wr_pa_dir;
    wire                wr_pb_dir;
    wire                wr_pd_data;
    wire                wr_pd_dir;
    wire                wr_pd_pad;
    wire                wr_pd_sel;

    // read views of the wide ports
    wire [`WIDE_W-1:0]  pa_rd;
    wire [`WIDE_W-1:0]  pb_rd;
    wire [`WIDE_W-1:0]  pa_dir_rd;
    wire [`WIDE_W-1:0]  pb_dir_rd;

    // narrow port state
    reg  [`PD_W-1:0]    pd_latch_reg;
    reg  [`PD_W-1:0]    pd_dir_reg;
    reg  [`PD_W-1:0]    pd_pad_reg;
    reg  [`PD_W-1:0]    pd_sel_reg;
    wire [`PD_W-1:0]    pd_level;
    wire [`PD_W-1:0]    pd_rd;
    wire [`PD_W-1:0]    pd_out_next;
    wire [`PD_W-1:0]    pd_oe_next;
    wire [`PD_W-1:0]    pd_pull_next;

    // word index and alignment of the current address
    assign idx     = PADDR[`ADDR_IDX_HI:`ADDR_IDX_LO];
    assign aligned = (PADDR[1:0] == `ADDR_ALIGN);

    // access is the first access cycle, commit the completing edge
    assign access = PSEL & PENABLE & (state_reg == ST_IDLE);
    assign commit = PSEL & PENABLE & (state_reg == ST_ACK);

    // read mux; unmapped or unaligned words answer with an error
    always @* begin
        hit     = aligned;
        rd_byte = `DIR_RESET;
        case (idx)
            `IDX_PA_DATA: begin
                rd_byte = pa_rd;
            end
            `IDX_PB_DATA: begin
                rd_byte = pb_rd;
            end
            `IDX_PA_DIR: begin
                rd_byte = pa_dir_rd;
            end
            `IDX_PB_DIR: begin
                rd_byte = pb_dir_rd;
            end
            `IDX_PD_DATA: begin
                rd_byte = {`PD_UNUSED_BITS, pd_rd};
            end
            `IDX_PD_DIR: begin
                rd_byte = {`PD_UNUSED_BITS, pd_dir_reg};
            end
            `IDX_PD_PAD: begin
                rd_byte = {`PD_UNUSED_BITS, pd_pad_reg};
            end
            `IDX_PD_SEL: begin
                rd_byte = {`PD_UNUSED_BITS, pd_sel_reg};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // one wait state: answer is prepared in the first access cycle
    always @* begin
        state_next   = state_reg;
        prdata_next  = PRDATA;
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (access) begin
                    state_next   = ST_ACK;
                    pready_next  = 1'b1;
                    pslverr_next = ~hit;
                    if (!PWRITE && hit) begin
                        prdata_next = {`RD_PAD_WIDE, rd_byte};
                    end else begin
                        prdata_next = 32'h00000000;
                    end
                end
            end
            ST_ACK: begin
                // transfer ends at this edge whatever the master does next
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            PRDATA    <= 32'h00000000;
            PREADY    <= 1'b0;
            PSLVERR   <= 1'b0;
        end else begin
            state_reg <= state_next;
            PRDATA    <= prdata_next;
            PREADY    <= pready_next;
            PSLVERR   <= pslverr_next;
        end
    end

    // writes land only on the edge that samples ready, never on errors
    assign wr_pa_data = commit & PWRITE & hit & (idx == `IDX_PA_DATA);
    assign wr_pb_data = commit & PWRITE & hit & (idx == `IDX_PB_DATA);
    assign wr_pa_dir  = commit & PWRITE & hit & (idx == `IDX_PA_DIR);
    assign wr_pb_dir  = commit & PWRITE & hit & (idx == `IDX_PB_DIR);
    assign wr_pd_data = commit & PWRITE & hit & (idx == `IDX_PD_DATA);
    assign wr_pd_dir  = commit & PWRITE & hit & (idx == `IDX_PD_DIR);
    assign wr_pd_pad  = commit & PWRITE & hit & (idx == `IDX_PD_PAD);
    assign wr_pd_sel  = commit & PWRITE & hit & (idx == `IDX_PD_SEL);

    // the two eight-line ports share one structure
    wide_port u_port_a (
        .clk      (CLK),
        .rst      (RST),
        .wr_data  (PWDATA[`WIDE_W-1:0]),
        .wr_latch (wr_pa_data),
        .wr_dir   (wr_pa_dir),
        .pin_in   (PA_IN),
        .rd_data  (pa_rd),
        .rd_dir   (pa_dir_rd),
        .pin_out  (PA_OUT),
        .pin_oe   (PA_OE)
    );

    wide_port u_port_b (
        .clk      (CLK),
        .rst      (RST),
        .wr_data  (PWDATA[`WIDE_W-1:0]),
        .wr_latch (wr_pb_data),
        .wr_dir   (wr_pb_dir),
        .pin_in   (PB_IN),
        .rd_data  (pb_rd),
        .rd_dir   (pb_dir_rd),
        .pin_out  (PB_OUT),
        .pin_oe   (PB_OE)
    );

    // narrow latch keeps its contents over reset; bits 7:6 dropped
    always @(posedge CLK) begin
        if (wr_pd_data) begin
            pd_latch_reg <= PWDATA[`PD_W-1:0];
        end
    end

    // narrow port configuration, cleared by reset
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            pd_dir_reg <= `PD_CFG_RESET;
            pd_pad_reg <= `PD_CFG_RESET;
            pd_sel_reg <= `PD_CFG_RESET;
        end else begin
            if (wr_pd_dir) begin
                pd_dir_reg <= PWDATA[`PD_W-1:0];
            end
            if (wr_pd_pad) begin
                pd_pad_reg <= PWDATA[`PD_W-1:0];
            end
            if (wr_pd_sel) begin
                pd_sel_reg <= PWDATA[`PD_W-1:0];
            end
        end
    end

    pin_sync #(
        .WIDTH (`PD_W)
    ) u_pd_sync (
        .clk    (CLK),
        .rst    (RST),
        .pin_in (PD_IN),
        .level  (pd_level)
    );

    // per-line masks as vectors so each line takes exactly one bit
    localparam [`PD_W-1:0] alt_drives = `PD_ALT_DRIVES;
    localparam [`PD_W-1:0] alt_od     = `PD_ALT_OD;

    // per-line pad decode for the narrow port
    genvar i;
    generate
        for (i = 0; i < `PD_W; i = i + 1) begin : g_pd
            wire       sel;
            wire       dir_eff;
            wire       drive_val;
            wire       od;
            wire [1:0] cfg;

            assign sel = pd_sel_reg[i];
            assign cfg = {pd_dir_reg[i], pd_pad_reg[i]};
            // select wins over the direction bit
            assign dir_eff = sel ? alt_drives[i]
                                 : pd_dir_reg[i];
            assign drive_val = sel ? ALT_OUT[i] : pd_latch_reg[i];
            // two-wire lines open drain whenever selected; otherwise pad bit decides
            assign od = (sel & alt_od[i])
                      | (dir_eff & pd_pad_reg[i]);
            // open drain only ever pulls low
            assign pd_oe_next[i] = dir_eff & (~od | ~drive_val);
            assign pd_out_next[i] = drive_val & ~od;
            // pull-up only in the 00 decode, select or not
            assign pd_pull_next[i] = (cfg == `PAD_IN_PULLUP);
            assign pd_rd[i] = dir_eff ? pd_latch_reg[i]
                                      : pd_level[i];
        end
    endgenerate

    // narrow pad drivers and subsystem input view, all registered
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            PD_OUT    <= `PD_PIN_RESET;
            PD_OE     <= `PD_PIN_RESET;
            PD_PULLUP <= `PD_PIN_RESET;
            PD_ALT_IN <= `PD_PIN_RESET;
        end else begin
            PD_OUT    <= pd_out_next & pd_oe_next; // masks unset latch
            PD_OE     <= pd_oe_next;
            PD_PULLUP <= pd_pull_next;
            PD_ALT_IN <= pd_level;
        end
    end
endmodule
`default_nettype wire

/* dv/gpio_top_props.sv */
`timescale 1ns/10ps
`default_nettype none
module gpio_top_props (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [31:0] PRDATA,
    input  wire logic        PREADY,
    input  wire logic        PSLVERR,
    input  wire logic [7:0]  PA_OUT,
    input  wire logic [7:0]  PA_OE,
    input  wire logic [7:0]  PB_OUT,
    input  wire logic [7:0]  PB_OE,
    input  wire logic [5:0]  PD_OE,
    input  wire logic [5:0]  PD_PULLUP
);
    // one clock domain, so one default for all properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    ready_wait_a: assert property ($rose(PENABLE) && PSEL |=> PREADY)
        else $error("ready missing after one wait state");
    ready_one_a: assert property (PREADY |=> !PREADY)
        else $error("ready held past one cycle");
    ready_req_a: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready without an access phase");
    dir_reset_a: assert property ($fell(RST) |->
        PA_OE == 8'h00 && PB_OE == 8'h00 && PD_OE == 6'h00)
        else $error("line driven right after reset");
    oe_follow_a: assert property (PREADY && PWRITE && !PSLVERR &&
        PADDR == 8'h10 |-> ##2 PA_OE == $past(PWDATA[7:0], 2))
        else $error("enable does not follow direction write");
    out_mask_a: assert property
        (((PA_OUT & ~PA_OE) | (PB_OUT & ~PB_OE)) == 8'h00)
        else $error("value shown on an undriven line");
    pull_dir_a: assert property (PREADY && PWRITE && !PSLVERR &&
        PADDR == 8'hC4 && PWDATA[5:0] == 6'h3F |-> ##2 PD_PULLUP == 6'h00)
        else $error("pull-up left on output lines");
    err_zero_a: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
        else $error("error answer carries data");
    narrow_read_a: assert property (PREADY && !PWRITE &&
        PADDR[7:4] == 4'hC |-> PRDATA[31:6] == 26'h0)
        else $error("narrow port upper bits not zero");
endmodule
`default_nettype wire

/* dv/pin_board.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_board (
    input  wire logic       clash,
    input  wire logic [7:0] ext_a,
    input  wire logic [7:0] ext_b,
    input  wire logic [5:0] ext_d,
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe,
    input  wire logic [5:0] pd_out,
    input  wire logic [5:0] pd_oe,
    input  wire logic [5:0] pd_pull,
    output logic      [7:0] pa_in,
    output logic      [7:0] pb_in,
    output logic      [5:0] pd_in
);
    // board overrides driven port A lines only when a clash is commanded
    assign pa_in = clash ? ext_a : (pa_oe & pa_out) | (~pa_oe & ext_a);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
    // pull-up wins over a floating board line
    assign pd_in = (pd_oe & pd_out) | (~pd_oe & (pd_pull | ext_d));
endmodule
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, clash, err;
    logic [7:0]  PADDR, PA_IN, PA_OUT, PA_OE, PB_IN, PB_OUT, PB_OE, ext_a, ext_b;
    logic [31:0] PWDATA, PRDATA, rdat;
    logic [5:0]  PD_IN, PD_OUT, PD_OE, PD_PULLUP, ALT_OUT, PD_ALT_IN, ext_d;
    int          n_fail, checks_done;
    logic [7:0]  cfg [5] = '{8'h10, 8'h14, 8'hC4, 8'hC8, 8'hCC};
    logic [17:0] pdo [4] = '{18'h0003F, 18'h0, 18'h3FA80, 18'h15000};
    logic [5:0]  pdr [4] = '{6'h3F, 6'h00, 6'h2A, 6'h2A};

    gpio_top dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PA_IN(PA_IN), .PA_OUT(PA_OUT),
        .PA_OE(PA_OE), .PB_IN(PB_IN), .PB_OUT(PB_OUT), .PB_OE(PB_OE),
        .PD_IN(PD_IN), .PD_OUT(PD_OUT), .PD_OE(PD_OE),
        .PD_PULLUP(PD_PULLUP), .ALT_OUT(ALT_OUT), .PD_ALT_IN(PD_ALT_IN));
    pin_board board (.clash(clash), .ext_a(ext_a), .ext_b(ext_b),
        .ext_d(ext_d), .pa_out(PA_OUT), .pa_oe(PA_OE), .pb_out(PB_OUT),
        .pb_oe(PB_OE), .pd_out(PD_OUT), .pd_oe(PD_OE), .pd_pull(PD_PULLUP),
        .pa_in(PA_IN), .pb_in(PB_IN), .pd_in(PD_IN));

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // request held until ready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL    <= 1'h1;
        PENABLE <= 1'h0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLK);
        PENABLE <= 1'h1;
        do @(posedge CLK); while (PREADY !== 1'h1);
        rdat = PRDATA;
        err  = PSLVERR;
        PSEL    <= 1'h0;
        PENABLE <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(rdat, x);
    endtask

    task automatic finish_test;
        if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // free-running bus clock
    initial begin
        CLK = 1'h0;
        forever #12.5 CLK = ~CLK;
    end

    // watchdog cuts a hung handshake short
    initial begin
        repeat (4000) @(posedge CLK);
        n_fail++;
        finish_test();
    end

    initial begin
        {RST, PSEL, PENABLE, PWRITE, clash} = 5'h10;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        {ext_a, ext_b, ext_d, ALT_OUT} = {8'h5A, 8'hA5, 6'h00, 6'h15};
        n_fail = 0;
        checks_done = 0;
        repeat (12) @(posedge CLK);
        RST <= 1'h0;
        foreach (cfg[i]) rd(cfg[i], 32'h0);
        chk(32'({PA_OE, PB_OE, PD_OE}), 32'h0);
        apb(1'h1, 8'h10, 32'hA5);
        rd(8'h10, 32'hA5);
        apb(1'h1, 8'h14, 32'h5A);
        rd(8'h14, 32'h5A);
        // refused accesses: unaligned write, unmapped read
        apb(1'h1, 8'h11, 32'hFF);
        chk({31'h0, err}, 32'h1);
        rd(8'h10, 32'hA5);
        apb(1'h0, 8'h08, 32'h0);
        chk({err, rdat[30:0]}, 32'h80000000);
        // latch first, then direction, as software should
        apb(1'h1, 8'h10, 32'h0);
        apb(1'h1, 8'h00, 32'h96);
        repeat (2) @(posedge CLK);
        chk(32'({PA_OE, PA_OUT}), 32'h0);
        apb(1'h1, 8'h10, 32'hFF);
        repeat (2) @(posedge CLK);
        chk(32'({PA_OE, PA_OUT}), 32'hFF96);
        // board fights the outputs: reads must still show the latch
        apb(1'h1, 8'h10, 32'h0F);
        clash <= 1'h1;
        repeat (6) @(posedge CLK);
        rd(8'h00, 32'h56);
        clash <= 1'h0;
        apb(1'h1, 8'h04, 32'h3C);
        apb(1'h1, 8'h14, 32'hF0);
        repeat (6) @(posedge CLK);
        rd(8'h04, 32'h35);
        chk(32'({PB_OE, PB_OUT}), 32'hF030);
        // second reset in mid-run keeps the latches
        RST <= 1'h1;
        repeat (2) @(posedge CLK);
        RST <= 1'h0;
        rd(8'h14, 32'h0);
        apb(1'h1, 8'h10, 32'hFF);
        rd(8'h00, 32'h96);
        // every direction/pad code on the narrow port
        apb(1'h1, 8'hC0, 32'h2A);
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, 8'hC4, i[1] ? 32'h3F : 32'h0);
            apb(1'h1, 8'hC8, i[0] ? 32'h3F : 32'h0);
            repeat (6) @(posedge CLK);
            chk(32'({PD_OE, PD_OUT, PD_PULLUP}), 32'(pdo[i]));
            rd(8'hC0, 32'(pdr[i]));
        end
        apb(1'h1, 8'hC4, 32'hFF);
        rd(8'hC4, 32'h3F);
        // lines handed to timer and two-wire logic
        apb(1'h1, 8'hC4, 32'h0);
        apb(1'h1, 8'hC8, 32'h0);
        apb(1'h1, 8'hCC, 32'h3F);
        repeat (7) @(posedge CLK);
        chk(32'({PD_OE, PD_OUT, PD_PULLUP}), 32'h2A03F);
        chk(32'(PD_ALT_IN), 32'h15);
        rd(8'hCC, 32'h3F);
        apb(1'h1, 8'hC4, 32'h3F);
        repeat (3) @(posedge CLK);
        chk(32'({PD_OE, PD_OUT, PD_PULLUP}), 32'h2A000);
        finish_test();
    end
endmodule

bind gpio_top gpio_top_props props_i (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PA_OUT(PA_OUT),
    .PA_OE(PA_OE), .PB_OUT(PB_OUT), .PB_OE(PB_OE), .PD_OE(PD_OE),
    .PD_PULLUP(PD_PULLUP));
`default_nettype wire
